// ---- dsp_status_and_multiply_datapath.sv ----
// status words, scaling shifter, multiplier, product shifter and stack of a dsp core
// assumes op and event strobes come from the decoder on the same clock, one op a cycle
`timescale 1ns/100ps
module dsp_status_and_multiply_datapath
  import dsp_status_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          ce,
  input  dsp_status_pkg::op_t                op,
  input  dsp_status_pkg::bit_sel_t           bit_sel,
  input  wire logic [dsp_status_pkg::DATA_W-1:0] op_data,
  input  wire logic [dsp_status_pkg::DATA_W-1:0] mul_operand,
  input  wire logic [dsp_status_pkg::DATA_W-1:0] test_word,
  input  wire logic [dsp_status_pkg::OFFS_W-1:0] instr_offset,
  input  wire logic                          alu_add,
  input  wire logic                          alu_sub,
  input  wire logic                          alu_carry_out,
  input  wire logic                          alu_shift16,
  input  wire logic                          alu_overflow,
  input  wire logic                          overflow_positive,
  input  wire logic [dsp_status_pkg::WIDE_W-1:0] alu_result,
  input  wire logic                          trap_taken,
  input  wire logic                          bit_test_ev,
  input  wire logic                          bit_test_value,
  input  wire logic                          aux_compare_ev,
  input  wire logic                          aux_compare_true,
  input  wire logic                          align_ev,
  input  wire logic [1:0]                    sum_top_bits,
  input  wire logic [dsp_status_pkg::DATA_W-1:0] scale_data,
  input  wire logic [dsp_status_pkg::SCNT_W-1:0] scale_count,
  input  wire logic                          scale_use_temp,
  input  wire logic                          scale_no_extend,
  input  wire logic                          stack_push,
  input  wire logic                          stack_pop,
  input  wire logic [dsp_status_pkg::STACK_W-1:0] stack_push_data,
  output logic      [dsp_status_pkg::DATA_W-1:0]  status_word_zero,
  output logic      [dsp_status_pkg::DATA_W-1:0]  status_word_one,
  output logic                               flag_output_pin,
  output logic      [dsp_status_pkg::DATA_W-1:0]  direct_addr_reg,
  output logic      [dsp_status_pkg::WIDE_W-1:0]  product_reg,
  output logic      [dsp_status_pkg::WIDE_W-1:0]  product_shifted_reg,
  output logic      [dsp_status_pkg::WIDE_W-1:0]  scaled_reg,
  output logic      [dsp_status_pkg::WIDE_W-1:0]  acc_load_reg,
  output logic      [dsp_status_pkg::STACK_W-1:0] stack_top_reg
);
  import dsp_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // status fields
  logic [PTR_W-1:0]  aux_pointer_reg, aux_pointer_next;
  logic [PTR_W-1:0]  aux_pointer_buffer_reg, aux_pointer_buffer_next;
  logic              arith_sticky_flag_reg, arith_sticky_flag_next;
  logic              saturate_enable_reg, saturate_enable_next;
  logic              global_irq_disable_reg, global_irq_disable_next;
  logic [PAGE_W-1:0] page_pointer_reg, page_pointer_next;
  logic              ram_map_select_reg, ram_map_select_next;
  logic              test_flag_reg, test_flag_next;
  logic              sign_extend_mode_reg, sign_extend_mode_next;
  logic              carry_reg, carry_next;
  logic              flag_out_reg, flag_out_next;
  logic [MODE_W-1:0] product_shift_mode_reg, product_shift_mode_next;
  logic [DATA_W-1:0] operand_temp_reg, operand_temp_next;
  logic [WIDE_W-1:0] product_next;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire is_load0   = (op == OP_LOAD_STATUS0);
  wire is_load1   = (op == OP_LOAD_STATUS1);
  wire is_set     = (op == OP_SET_BIT);
  wire is_clear   = (op == OP_CLEAR_BIT);
  wire is_bit_op  = is_set | is_clear;
  wire is_mpy     = (op == OP_MULTIPLY);
  wire is_unsigned_multiply_op    = (op == OP_MULTIPLY_UNSIGNED);
  wire is_dyntest = (op == OP_DYNAMIC_TEST);
  wire bit_value  = is_set;
  wire [TBIT_W-1:0] dyn_bit_pos = operand_temp_reg[TBIT_W-1:0];
  wire dyn_bit    = test_word[dyn_bit_pos];
  wire leading_align_op_xor   = sum_top_bits[1] ^ sum_top_bits[0];

  ////////////////////////////////////////////////////////////////////////////
  // product shifter
  function automatic logic [WIDE_W-1:0] shift_product(input logic [WIDE_W-1:0] p,
                                                      input logic [MODE_W-1:0] m);
    case (m)
      PMODE_NONE: shift_product = p;
      PMODE_L1:   shift_product = p << SHIFT_L1;
      PMODE_L4:   shift_product = p << SHIFT_L4;
      PMODE_R6:   shift_product = WIDE_W'($signed(p) >>> SHIFT_R6);
      default:    shift_product = p;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // status next state
  always_comb begin
    aux_pointer_next        = aux_pointer_reg;
    aux_pointer_buffer_next = aux_pointer_buffer_reg;
    arith_sticky_flag_next  = arith_sticky_flag_reg;
    saturate_enable_next    = saturate_enable_reg;
    global_irq_disable_next = global_irq_disable_reg;
    page_pointer_next       = page_pointer_reg;
    ram_map_select_next     = ram_map_select_reg;
    test_flag_next          = test_flag_reg;
    sign_extend_mode_next   = sign_extend_mode_reg;
    carry_next              = carry_reg;
    flag_out_next           = flag_out_reg;
    product_shift_mode_next = product_shift_mode_reg;
    case (op)
      OP_LOAD_STATUS0: begin
        aux_pointer_next       = op_data[S0_PTR_HI:S0_PTR_LO];
        arith_sticky_flag_next = op_data[S0_OVF];
        saturate_enable_next   = op_data[S0_SAT];
        page_pointer_next      = op_data[S0_PAGE_HI:0];
      end
      OP_LOAD_STATUS1: begin
        aux_pointer_buffer_next = op_data[S1_BUF_HI:S1_BUF_LO];
        aux_pointer_next        = op_data[S1_BUF_HI:S1_BUF_LO];
        ram_map_select_next     = op_data[S1_MAP];
        test_flag_next          = op_data[S1_TEST];
        sign_extend_mode_next   = op_data[S1_SXT];
        carry_next              = op_data[S1_CARRY];
        flag_out_next           = op_data[S1_FLAG];
        product_shift_mode_next = op_data[S1_MODE_HI:0];
      end
      OP_SET_BIT, OP_CLEAR_BIT: begin
        case (bit_sel)
          BIT_CARRY:       carry_next              = bit_value;
          BIT_RAM_MAP:     ram_map_select_next     = bit_value;
          BIT_IRQ_DISABLE: global_irq_disable_next = bit_value;
          BIT_SATURATE:    saturate_enable_next    = bit_value;
          BIT_SIGN_EXTEND: sign_extend_mode_next   = bit_value;
          BIT_TEST:        test_flag_next          = bit_value;
          BIT_FLAG_OUT:    flag_out_next           = bit_value;
          default:         ;
        endcase
      end
      OP_AUX_PTR_LOAD: begin
        aux_pointer_buffer_next = aux_pointer_reg;
        aux_pointer_next        = op_data[PTR_W-1:0];
      end
      OP_PAGE_LOAD:          page_pointer_next       = op_data[PAGE_W-1:0];
      OP_PMODE_LOAD:         product_shift_mode_next = op_data[MODE_W-1:0];
      OP_BRANCH_ON_OVERFLOW: arith_sticky_flag_next  = 1'b0;
      OP_DYNAMIC_TEST:       test_flag_next          = dyn_bit;
      default:               ;
    endcase
    // alu and core events override the op, so a trap still sets irq disable during a clear of that bit
    if (alu_add) begin
      carry_next = alu_shift16 ? (carry_reg | alu_carry_out) : alu_carry_out;
    end else if (alu_sub) begin
      carry_next = alu_shift16 ? (carry_reg & alu_carry_out) : alu_carry_out;
    end
    if (bit_test_ev)    test_flag_next = bit_test_value;
    if (aux_compare_ev) test_flag_next = aux_compare_true;
    if (align_ev)       test_flag_next = leading_align_op_xor;
    if (alu_overflow)   arith_sticky_flag_next = 1'b1;
    if (trap_taken)     global_irq_disable_next = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiplier, scaler, saturation
  wire signed [WIDE_W-1:0] prod_signed = $signed(operand_temp_reg) * $signed(mul_operand);
  wire [WIDE_W-1:0] prod_unsigned = operand_temp_reg * mul_operand;

  assign operand_temp_next = (op == OP_TEMP_LOAD) ? op_data : operand_temp_reg;
  assign product_next = is_unsigned_multiply_op ? prod_unsigned :
                        is_mpy  ? WIDE_W'(prod_signed) : product_reg;

  wire [SCNT_W-1:0] scale_amount = scale_use_temp ?
                                   SCNT_W'(operand_temp_reg[TBIT_W-1:0]) : scale_count;
  wire scale_extend = sign_extend_mode_reg & ~scale_no_extend;
  wire [WIDE_W-1:0] scale_wide = {{DATA_W{scale_extend & scale_data[DATA_W-1]}}, scale_data};
  wire [WIDE_W-1:0] scale_next = scale_wide << scale_amount;

  wire [WIDE_W-1:0] acc_next = (alu_overflow && saturate_enable_reg) ?
                               (overflow_positive ? SAT_POS : SAT_NEG) : alu_result;

  wire [DATA_W-1:0] word0_next = S0_RSV_MASK | {aux_pointer_next, arith_sticky_flag_next,
                                 saturate_enable_next, 1'b0, global_irq_disable_next,
                                 page_pointer_next};
  wire [DATA_W-1:0] word1_next = S1_RSV_MASK | {aux_pointer_buffer_next, ram_map_select_next,
                                 test_flag_next, sign_extend_mode_next, carry_next, 4'h0,
                                 flag_out_next, 2'h0, product_shift_mode_next};

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aux_pointer_reg        <= '0;
      aux_pointer_buffer_reg <= '0;
      arith_sticky_flag_reg  <= 1'b0;
      saturate_enable_reg    <= 1'b0;
      global_irq_disable_reg <= RST_IRQ;
      page_pointer_reg       <= '0;
      ram_map_select_reg     <= RST_MAP;
      test_flag_reg          <= 1'b0;
      sign_extend_mode_reg   <= RST_SXT;
      carry_reg              <= RST_CARRY;
      flag_out_reg           <= RST_FLAG;
      product_shift_mode_reg <= RST_MODE;
    end else if (ce) begin
      aux_pointer_reg        <= aux_pointer_next;
      aux_pointer_buffer_reg <= aux_pointer_buffer_next;
      arith_sticky_flag_reg  <= arith_sticky_flag_next;
      saturate_enable_reg    <= saturate_enable_next;
      global_irq_disable_reg <= global_irq_disable_next;
      page_pointer_reg       <= page_pointer_next;
      ram_map_select_reg     <= ram_map_select_next;
      test_flag_reg          <= test_flag_next;
      sign_extend_mode_reg   <= sign_extend_mode_next;
      carry_reg              <= carry_next;
      flag_out_reg           <= flag_out_next;
      product_shift_mode_reg <= product_shift_mode_next;
    end
  end

  // outputs carry next-state images so the following op sees fresh status
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      operand_temp_reg    <= '0;
      product_reg         <= '0;
      product_shifted_reg <= '0;
      scaled_reg          <= '0;
      acc_load_reg        <= '0;
      status_word_zero    <= S0_RSV_MASK | (DATA_W'(RST_IRQ) << S0_IRQ);
      status_word_one     <= S1_RSV_MASK | (DATA_W'(RST_SXT) << S1_SXT)
                             | (DATA_W'(RST_CARRY) << S1_CARRY) | (DATA_W'(RST_FLAG) << S1_FLAG);
      flag_output_pin     <= RST_FLAG;
      direct_addr_reg     <= '0;
    end else if (ce) begin
      operand_temp_reg    <= operand_temp_next;
      product_reg         <= product_next;
      product_shifted_reg <= shift_product(product_next, product_shift_mode_next);
      scaled_reg          <= scale_next;
      acc_load_reg        <= acc_next;
      status_word_zero    <= word0_next;
      status_word_one     <= word1_next;
      flag_output_pin     <= flag_out_next;
      direct_addr_reg     <= {page_pointer_next, instr_offset};
    end
  end

  hw_stack #(
    .WIDTH (STACK_W),
    .DEPTH (STACK_D)
  ) u_stack (
    .clk       (clk),
    .resetn    (resetn),
    .ce        (ce),
    .push      (stack_push),
    .pop       (stack_pop),
    .push_data (stack_push_data),
    .top_reg   (stack_top_reg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_carry_add;
    ce && alu_add && !alu_shift16 |=> status_word_one[S1_CARRY] == $past(alu_carry_out);
  endproperty
  a_carry_add: assert property (p_carry_add) else $error("carry wrong after add");

  property p_ovf_set;
    ce && alu_overflow |=> status_word_zero[S0_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_sticky;
    status_word_zero[S0_OVF] && !(ce && (is_load0 || op == OP_BRANCH_ON_OVERFLOW))
      |=> status_word_zero[S0_OVF];
  endproperty
  a_sticky: assert property (p_sticky) else $error("overflow flag not sticky");

  property p_irq_trap;
    ce && trap_taken |=> status_word_zero[S0_IRQ];
  endproperty
  a_irq_trap: assert property (p_irq_trap) else $error("trap did not disable irqs");

  property p_irq_keep;
    ce && is_load0 && !trap_taken |=> $stable(status_word_zero[S0_IRQ]);
  endproperty
  a_irq_keep: assert property (p_irq_keep) else $error("status load changed irq bit");

  property p_buf_copy;
    ce && op == OP_AUX_PTR_LOAD |=>
      status_word_one[S1_BUF_HI:S1_BUF_LO] == $past(status_word_zero[S0_PTR_HI:S0_PTR_LO]);
  endproperty
  a_buf_copy: assert property (p_buf_copy) else $error("pointer buffer not copied");

  property p_load1_ptr;
    ce && is_load1 |=> status_word_zero[S0_PTR_HI:S0_PTR_LO] == $past(op_data[S1_BUF_HI:S1_BUF_LO]);
  endproperty
  a_load1_ptr: assert property (p_load1_ptr) else $error("pointer not loaded from buffer");

  property p_pshift;
    product_shifted_reg == shift_product(product_reg, status_word_one[S1_MODE_HI:0]);
  endproperty
  a_pshift: assert property (p_pshift) else $error("product shifter mismatch");

  property p_unsigned_multiply_op;
    ce && is_unsigned_multiply_op |=> product_reg == $past(operand_temp_reg) * $past(mul_operand);
  endproperty
  a_unsigned_multiply_op: assert property (p_unsigned_multiply_op) else $error("unsigned product wrong");

  property p_reserved;
    (status_word_zero & S0_RSV_MASK) == S0_RSV_MASK && (status_word_one & S1_RSV_MASK) == S1_RSV_MASK;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit read zero");

  property p_sat;
    ce && alu_overflow && saturate_enable_reg |=>
      acc_load_reg == ($past(overflow_positive) ? SAT_POS : SAT_NEG);
  endproperty
  a_sat: assert property (p_sat) else $error("saturation value wrong");

  property p_page_keep;
    ce && op != OP_LOAD_STATUS0 && op != OP_PAGE_LOAD |=> $stable(status_word_zero[S0_PAGE_HI:0]);
  endproperty
  a_page_keep: assert property (p_page_keep) else $error("page changed by other op");

  property p_dyntest;
    ce && is_dyntest && !bit_test_ev && !aux_compare_ev && !align_ev |=>
      status_word_one[S1_TEST] == $past(dyn_bit);
  endproperty
  a_dyntest: assert property (p_dyntest) else $error("dynamic bit test wrong");

  c_mpy:      cover property (ce && is_mpy);
  c_sat:      cover property (ce && alu_overflow && saturate_enable_reg);
  c_load1:    cover property (ce && is_load1);
  c_trap_irq: cover property (ce && trap_taken && is_clear && bit_sel == BIT_IRQ_DISABLE);
endmodule

// ---- dsp_status_and_multiply_datapath_tb.sv ----
// self-checking bench for the status and multiply datapath
// assumes the design package is compiled first; bench drives every port directly
`timescale 1ns/100ps
module dsp_status_and_multiply_datapath_tb;
  import dsp_status_pkg::*;
  logic clk, resetn, ce, alu_add, alu_sub, alu_carry_out, alu_shift16, alu_overflow;
  logic overflow_positive, trap_taken, bit_test_ev, bit_test_value, aux_compare_ev;
  logic aux_compare_true, align_ev, scale_use_temp, scale_no_extend, stack_push, stack_pop;
  logic flag_output_pin;
  logic [1:0] sum_top_bits;
  logic [4:0] scale_count;
  logic [6:0] instr_offset;
  logic [15:0] op_data, mul_operand, test_word, scale_data, stack_push_data;
  logic [15:0] status_word_zero, status_word_one, direct_addr_reg, stack_top_reg;
  logic [31:0] alu_result, product_reg, product_shifted_reg, scaled_reg, acc_load_reg;
  op_t op;
  bit_sel_t bit_sel;
  int miscompares, tests_run;
  logic [31:0] shifted_exp [4] = '{32'hFFFFFFFA, 32'hFFFFFFF4, 32'hFFFFFFA0, 32'hFFFFFFFF};
  //////////////////////////////////////////////////////////////////////////////
  dsp_status_and_multiply_datapath i_dut (.clk(clk), .resetn(resetn), .ce(ce), .op(op),
    .bit_sel(bit_sel), .op_data(op_data), .mul_operand(mul_operand), .test_word(test_word),
    .instr_offset(instr_offset), .alu_add(alu_add), .alu_sub(alu_sub),
    .alu_carry_out(alu_carry_out), .alu_shift16(alu_shift16), .alu_overflow(alu_overflow),
    .overflow_positive(overflow_positive), .alu_result(alu_result), .trap_taken(trap_taken),
    .bit_test_ev(bit_test_ev), .bit_test_value(bit_test_value),
    .aux_compare_ev(aux_compare_ev), .aux_compare_true(aux_compare_true),
    .align_ev(align_ev), .sum_top_bits(sum_top_bits), .scale_data(scale_data),
    .scale_count(scale_count), .scale_use_temp(scale_use_temp),
    .scale_no_extend(scale_no_extend), .stack_push(stack_push), .stack_pop(stack_pop),
    .stack_push_data(stack_push_data), .status_word_zero(status_word_zero),
    .status_word_one(status_word_one), .flag_output_pin(flag_output_pin),
    .direct_addr_reg(direct_addr_reg), .product_reg(product_reg),
    .product_shifted_reg(product_shifted_reg), .scaled_reg(scaled_reg),
    .acc_load_reg(acc_load_reg), .stack_top_reg(stack_top_reg));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one op per call, outputs looked at just after the taking edge
  task automatic step(input op_t o, input logic [15:0] d, input logic [1:0] ov = 2'b00,
                      input bit_sel_t b = BIT_CARRY);
    @(posedge clk);
    op <= o;
    op_data <= d;
    {alu_overflow, overflow_positive} <= ov;
    bit_sel <= b;
    @(posedge clk);
    op <= OP_IDLE;
    alu_overflow <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, alu_add, alu_sub, alu_carry_out, alu_shift16, alu_overflow} = '0;
    {overflow_positive, trap_taken, bit_test_ev, bit_test_value, aux_compare_ev} = '0;
    {aux_compare_true, align_ev, scale_use_temp, scale_no_extend, stack_push} = '0;
    {stack_pop, sum_top_bits, op_data, test_word, stack_push_data} = '0;
    ce = 1'b1;
    op = OP_IDLE;
    bit_sel = BIT_CARRY;
    instr_offset = 7'h2A;
    mul_operand = 16'hFFFE;
    scale_data = 16'h8001;
    scale_count = 5'h04;
    alu_result = 32'h12345678;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk(status_word_zero, 32'h0600);
    chk(status_word_one, 32'h07FC);
    chk(flag_output_pin, 1'b1);
    $display("reset test done");
    step(OP_PAGE_LOAD, 16'h0005);
    chk(direct_addr_reg, {5'h0, 9'h005, 7'h2A});
    chk(scaled_reg, 32'hFFF80010);
    step(OP_TEMP_LOAD, 16'h0003);
    step(OP_MULTIPLY_UNSIGNED, 16'h0000);
    chk(product_reg, 32'h0002FFFA);
    step(OP_MULTIPLY, 16'h0000);
    chk(product_reg, 32'hFFFFFFFA);
    for (int m = 0; m < 4; m++) begin
      step(OP_PMODE_LOAD, 16'(m));
      chk(product_shifted_reg, shifted_exp[m]);
      chk(product_reg, 32'hFFFFFFFA);
    end
    $display("multiply test done");
    step(OP_AUX_PTR_LOAD, 16'h0005);
    step(OP_AUX_PTR_LOAD, 16'h0002);
    chk({status_word_zero[15:13], status_word_one[15:13]}, 6'h15);
    step(OP_LOAD_STATUS1, 16'h0000);
    chk({status_word_zero[15:13], status_word_one}, {3'h0, 16'h01EC});
    step(OP_IDLE, 16'h0000);
    chk(scaled_reg, 32'h00080010);
    $display("status load test done");
    step(OP_IDLE, 16'h0000, 2'b11);
    chk(acc_load_reg, 32'h12345678);
    step(OP_IDLE, 16'h0000);
    chk(status_word_zero[12], 1'b1);
    step(OP_BRANCH_ON_OVERFLOW, 16'h0000);
    chk(status_word_zero[12], 1'b0);
    step(OP_SET_BIT, 16'h0000, 2'b00, BIT_SATURATE);
    step(OP_IDLE, 16'h0000, 2'b11);
    chk(acc_load_reg, 32'h7FFFFFFF);
    step(OP_IDLE, 16'h0000, 2'b10);
    chk(acc_load_reg, 32'h80000000);
    step(OP_SET_BIT, 16'h0000, 2'b00, BIT_FLAG_OUT);
    chk(flag_output_pin, 1'b1);
    step(OP_CLEAR_BIT, 16'h0000, 2'b00, BIT_FLAG_OUT);
    chk(flag_output_pin, 1'b0);
    $display("overflow and flag test done");
    for (int i = 1; i <= 9; i++) begin
      @(posedge clk);
      stack_push <= 1'b1;
      stack_push_data <= 16'(i);
    end
    @(posedge clk);
    stack_push <= 1'b0;
    stack_pop <= 1'b1;
    #1;
    chk(stack_top_reg, 32'h00000009);
    repeat (7) @(posedge clk);
    stack_pop <= 1'b0;
    #1;
    chk(stack_top_reg, 32'h00000002);
    $display("stack test done");
    step(OP_SET_BIT, 16'h0000, 2'b00, BIT_SIGN_EXTEND);
    step(OP_SET_BIT, 16'h0000, 2'b00, BIT_RAM_MAP);
    chk(status_word_one[12], 1'b1);
    step(OP_CLEAR_BIT, 16'h0000, 2'b00, BIT_IRQ_DISABLE);
    chk(status_word_zero[9], 1'b0);
    @(posedge clk);
    {alu_add, alu_carry_out, align_ev, bit_test_ev} <= 4'hF;
    {sum_top_bits, scale_use_temp, scale_no_extend} <= 4'hB;
    trap_taken <= 1'b1;
    op <= OP_CLEAR_BIT;
    bit_sel <= BIT_IRQ_DISABLE;
    @(posedge clk);
    {alu_add, alu_sub, alu_shift16, align_ev, bit_test_ev} <= 5'h0C;
    {aux_compare_ev, trap_taken, scale_no_extend} <= 3'h4;
    op <= OP_IDLE;
    #1;
    chk(status_word_one[9], 1'b1);
    chk(status_word_one[11], 1'b1);
    chk(status_word_zero[9], 1'b1);
    chk(scaled_reg, 32'h00040008);
    @(posedge clk);
    {alu_shift16, alu_carry_out, aux_compare_ev, scale_use_temp} <= 4'h0;
    #1;
    chk(status_word_one[9], 1'b1);
    chk(status_word_one[11], 1'b0);
    chk(scaled_reg, 32'hFFFC0008);
    @(posedge clk);
    alu_sub <= 1'b0;
    #1;
    chk(status_word_one[9], 1'b0);
    $display("carry, test flag and scaler test done");
    tally_and_finish();
  end
endmodule

// ---- dsp_status_pkg.sv ----
// constants, field layout and operation codes of the status and multiply datapath
// assumes a single cpu clock; used by dsp_status_and_multiply_datapath and hw_stack
package dsp_status_pkg;

  localparam int DATA_W   = 16;
  localparam int WIDE_W   = 32;
  localparam int STACK_W  = 16;
  localparam int STACK_D  = 8;
  localparam int PAGE_W   = 9;
  localparam int OFFS_W   = 7;
  localparam int PTR_W    = 3;
  localparam int MODE_W   = 2;
  localparam int SCNT_W   = 5;
  localparam int TBIT_W   = 4;

  // status word zero fields
  localparam int S0_PTR_HI  = 15;
  localparam int S0_PTR_LO  = 13;
  localparam int S0_OVF     = 12;
  localparam int S0_SAT     = 11;
  localparam int S0_RSV     = 10;
  localparam int S0_IRQ     = 9;
  localparam int S0_PAGE_HI = 8;

  // status word one fields
  localparam int S1_BUF_HI  = 15;
  localparam int S1_BUF_LO  = 13;
  localparam int S1_MAP     = 12;
  localparam int S1_TEST    = 11;
  localparam int S1_SXT     = 10;
  localparam int S1_CARRY   = 9;
  localparam int S1_RSV_HI  = 8;
  localparam int S1_RSV_LO  = 5;
  localparam int S1_FLAG    = 4;
  localparam int S1_RSV2_HI = 3;
  localparam int S1_RSV2_LO = 2;
  localparam int S1_MODE_HI = 1;

  localparam logic [15:0] S0_RSV_MASK = 16'h0400;
  localparam logic [15:0] S1_RSV_MASK = 16'h01EC;

  // reset values
  localparam logic RST_CARRY = 1'b1;
  localparam logic RST_MAP   = 1'b0;
  localparam logic RST_IRQ   = 1'b1;
  localparam logic RST_SXT   = 1'b1;
  localparam logic RST_FLAG  = 1'b1;
  localparam logic [MODE_W-1:0] RST_MODE = 2'h0;

  // product shift modes and amounts
  localparam logic [MODE_W-1:0] PMODE_NONE = 2'h0;
  localparam logic [MODE_W-1:0] PMODE_L1   = 2'h1;
  localparam logic [MODE_W-1:0] PMODE_L4   = 2'h2;
  localparam logic [MODE_W-1:0] PMODE_R6   = 2'h3;
  localparam int SHIFT_L1 = 1;
  localparam int SHIFT_L4 = 4;
  localparam int SHIFT_R6 = 6;

  localparam logic [WIDE_W-1:0] SAT_POS = 32'h7FFFFFFF;
  localparam logic [WIDE_W-1:0] SAT_NEG = 32'h80000000;

  typedef enum logic [3:0] {
    OP_IDLE,
    OP_LOAD_STATUS0,
    OP_LOAD_STATUS1,
    OP_SET_BIT,
    OP_CLEAR_BIT,
    OP_AUX_PTR_LOAD,
    OP_PAGE_LOAD,
    OP_PMODE_LOAD,
    OP_TEMP_LOAD,
    OP_MULTIPLY,
    OP_MULTIPLY_UNSIGNED,
    OP_DYNAMIC_TEST,
    OP_BRANCH_ON_OVERFLOW
  } op_t;

  typedef enum logic [2:0] {
    BIT_CARRY,
    BIT_RAM_MAP,
    BIT_IRQ_DISABLE,
    BIT_SATURATE,
    BIT_SIGN_EXTEND,
    BIT_TEST,
    BIT_FLAG_OUT
  } bit_sel_t;

endpackage

// ---- hw_stack.sv ----
// eight-level push-down stack for return addresses and data
// assumes push and pop are single-cycle strobes from the same clock
`timescale 1ns/100ps
module hw_stack #(
  parameter int WIDTH = dsp_status_pkg::STACK_W,
  parameter int DEPTH = dsp_status_pkg::STACK_D
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] top_reg
);
  import dsp_status_pkg::*;

  logic [WIDTH-1:0] level_reg [DEPTH];

  assign top_reg = level_reg[0];

  // push shifts down (deepest lost), pop shifts up (deepest kept)
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) level_reg[i] <= '0;
    end else if (ce && push) begin
      level_reg[0] <= push_data;
      for (int i = 1; i < DEPTH; i++) level_reg[i] <= level_reg[i-1];
    end else if (ce && pop) begin
      for (int i = 0; i < DEPTH-1; i++) level_reg[i] <= level_reg[i+1];
    end
  end

  property p_push_top;
    @(posedge clk) disable iff (!resetn) ce && push |=> top_reg == $past(push_data);
  endproperty
  a_push_top: assert property (p_push_top) else $error("stack top not pushed");
endmodule
